// *** src/tmr_array.sv ***
// Eight-channel timer array: channel grouping, split halves, count clocks.
// Assumes an APB master on pclk and asynchronous timer input pins.
//
// Summary of operation
// - Only even channels may be masters.
// - Every channel but zero may be slave.
// - Masters forward irq, trigger, clock upward.
// - Masters never take a lower master's sources.
// - Channel zero master bit zero, still master.
// - Only channels one, three split.
// - Upper half interval only, irq at start.
// - Upper half uses lower clock select.
// - Upper half owns start, stop, active.
// - Lower half: interval, event only.
// - Upper controls inert in sixteen-bit mode.
// - Source select picks prescaled or pin edge.
// - Prescaled tick: one-cycle pulse or steady high.
// - Counter updates one cycle after tick.
// - Pin edge sampled by operating clock.
// - Filter needs two equal samples.
`default_nettype none
`include "tmr_cfg.svh"
module tmr_array
   import tmr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] timer_input_pin,
   output logic [7:0] channel_irq,
   output logic upper_half_irq_ch1,
   output logic upper_half_irq_ch3
);
   logic [15:0] channel_mode_reg [`TMR_NCH];
   logic [15:0] data_reg [`TMR_NCH];
   logic [15:0] count_value_reg [`TMR_NCH];
   logic [15:0] prescaler_select_reg;
   logic [7:0] filt_reg;
   tmr_chan_state_t state_reg [`TMR_NCH];
   tmr_chan_state_t up_state_reg [2];
   logic [7:0] up_cnt_reg [2];
   logic [7:0] irq_reg;
   logic [1:0] up_irq_reg;
   logic [`TMR_DIV_W-1:0] div_reg;
   logic [`TMR_NOPCLK-1:0] opclk;
   logic [7:0] is_master;
   logic [7:0] follow;
   logic [2:0] own_idx [`TMR_NCH];
   logic [2:0] src_idx [`TMR_NCH];
   logic [7:0] opk;
   logic [7:0] opk_q;
   logic [7:0] cnt_tick;
   logic [7:0] tick_q;
   logic [7:0] edge_pulse;
   logic [7:0] trig;
   logic [7:0] start_req;
   logic [7:0] stop_req;
   logic [7:0] split;
   logic [7:0] zero;
   logic [7:0] active;
   logic [1:0] up_start;
   logic [1:0] up_stop;
   logic wr_en;
   logic hit;
   logic [31:0] rd_data;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   always_comb begin
      rd_data = 32'h0000_0000;
      hit = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0);
      case (paddr[7:5])
         `TMR_SEG_MODE: rd_data = {16'h0000, channel_mode_reg[paddr[4:2]]};
         `TMR_SEG_DATA: rd_data = {16'h0000, data_reg[paddr[4:2]]};
         `TMR_SEG_COUNT: begin
            rd_data = {16'h0000, count_value_reg[paddr[4:2]]};
            if (paddr[4:2] == 3'h1 && split[1]) begin
               rd_data[15:8] = up_cnt_reg[0];
            end
            if (paddr[4:2] == 3'h3 && split[3]) begin
               rd_data[15:8] = up_cnt_reg[1];
            end
         end
         `TMR_SEG_CTRL: begin
            case (paddr[4:2])
               `TMR_CTRL_START: rd_data = 32'h0000_0000;
               `TMR_CTRL_STOP: rd_data = 32'h0000_0000;
               `TMR_CTRL_ACTIVE: begin
                  rd_data[7:0] = active;
                  rd_data[`TMR_UP_BASE + 1] = up_state_reg[0] != CH_STOP;
                  rd_data[`TMR_UP_BASE + 3] = up_state_reg[1] != CH_STOP;
               end
               `TMR_CTRL_PRESC: rd_data = {16'h0000, prescaler_select_reg};
               `TMR_CTRL_FILT: rd_data = {24'h00_0000, filt_reg};
               default: hit = 1'b0;
            endcase
         end
         default: hit = 1'b0;
      endcase
   end

   // The slave answers with zero wait states: pready rises in the access
   // phase that follows each setup cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= psel && !penable;
         pslverr_reg <= psel && !penable && !hit;
         if (psel && !penable && !pwrite) begin
            prdata_reg <= hit ? rd_data : 32'h0000_0000;
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign wr_en = psel && penable && pready_reg && pwrite && hit;

   // Writable mode bits per channel.
   function automatic logic [15:0] mode_mask(input int ch);
      logic [15:0] m;
      m = `TMR_MODE_WMASK;
      if (ch == 0) begin
         m[`TMR_MASTER] = 1'b0;
         m[`TMR_SLAVE] = 1'b0;
      end else if (ch % 2 == 1 && ch != 1 && ch != 3) begin
         m[`TMR_MASTER] = 1'b0;
      end
      return m;
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `TMR_NCH; i++) begin
            channel_mode_reg[i] <= `TMR_MODE_RST;
            data_reg[i] <= `TMR_DATA_RST;
         end
         prescaler_select_reg <= `TMR_PRESC_RST;
         filt_reg <= `TMR_FILT_RST;
      end else if (wr_en) begin
         if (paddr[7:5] == `TMR_SEG_MODE) begin
            channel_mode_reg[paddr[4:2]] <= pwdata[15:0] & mode_mask(int'(paddr[4:2]));
         end
         if (paddr[7:5] == `TMR_SEG_DATA) begin
            data_reg[paddr[4:2]] <= pwdata[15:0];
         end
         if (paddr[7:5] == `TMR_SEG_CTRL && paddr[4:2] == `TMR_CTRL_PRESC) begin
            prescaler_select_reg <= pwdata[15:0];
         end
         if (paddr[7:5] == `TMR_SEG_CTRL && paddr[4:2] == `TMR_CTRL_FILT) begin
            filt_reg <= pwdata[7:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Prescaler and operating clocks
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end

   // A divide by 2^k ticks when the low k divider bits are all ones; k of
   // zero leaves the tick steady high.
   always_comb begin
      logic [`TMR_DIV_W-1:0] m;
      logic [`TMR_PSEL_W-1:0] sel;
      m = '0;
      sel = '0;
      for (int k = 0; k < `TMR_NOPCLK; k++) begin
         sel = prescaler_select_reg[k*`TMR_PSEL_W +: `TMR_PSEL_W];
         m = `TMR_DIV_W'((16'h0001 << sel) - 16'h0001);
         opclk[k] = &(div_reg | ~m);
      end
   end

   // ---------------------------------------------------------------
   // Channel grouping and count tick selection
   // ---------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < `TMR_NCH; i++) begin
         is_master[i] = (i == 0) || (i % 2 == 0 && channel_mode_reg[i][`TMR_MASTER]);
         if (i == 0) begin
            own_idx[i] = 3'h0;
         end else begin
            own_idx[i] = is_master[i] ? 3'(i) : own_idx[i-1];
         end
         follow[i] = (i != 0) && !is_master[i] && channel_mode_reg[i][`TMR_SLAVE];
         src_idx[i] = follow[i] ? own_idx[i] : 3'(i);
         split[i] = (i == 1 || i == 3) && channel_mode_reg[i][`TMR_SPLIT];
         active[i] = state_reg[i] != CH_STOP;
      end
   end

   // Slaves run on their master's operating clock; in event mode a slave
   // counts the master's interrupts instead.
   always_comb begin
      for (int i = 0; i < `TMR_NCH; i++) begin
         opk[i] = opclk[channel_mode_reg[src_idx[i]][`TMR_CKS_HI:`TMR_CKS_LO]];
         if (channel_mode_reg[i][`TMR_CSS]) begin
            cnt_tick[i] = edge_pulse[i];
         end else if (follow[i] && channel_mode_reg[i][`TMR_EVENT]) begin
            cnt_tick[i] = irq_reg[src_idx[i]];
         end else begin
            cnt_tick[i] = opk[i];
         end
         if (follow[i]) begin
            trig[i] = state_reg[i] == CH_WAIT && state_reg[src_idx[i]] == CH_WAIT
               && tick_q[src_idx[i]];
         end else begin
            trig[i] = state_reg[i] == CH_WAIT && tick_q[i];
         end
         zero[i] = split[i] ? count_value_reg[i][7:0] == 8'h00 : count_value_reg[i] == 16'h0000;
         start_req[i] = wr_en && paddr[7:5] == `TMR_SEG_CTRL
            && paddr[4:2] == `TMR_CTRL_START && pwdata[i];
         stop_req[i] = wr_en && paddr[7:5] == `TMR_SEG_CTRL
            && paddr[4:2] == `TMR_CTRL_STOP && pwdata[i];
      end
      for (int j = 0; j < 2; j++) begin
         up_start[j] = wr_en && paddr[7:5] == `TMR_SEG_CTRL
            && paddr[4:2] == `TMR_CTRL_START && pwdata[`TMR_UP_BASE + 2*j + 1]
            && split[2*j+1];
         up_stop[j] = wr_en && paddr[7:5] == `TMR_SEG_CTRL
            && paddr[4:2] == `TMR_CTRL_STOP && pwdata[`TMR_UP_BASE + 2*j + 1]
            && split[2*j+1];
      end
   end

   genvar g;
   generate
      for (g = 0; g < `TMR_NCH; g++) begin : g_edge
         tmr_edge_detect u_edge (
            .pclk(pclk),
            .presetn(presetn),
            .pin_in(timer_input_pin[g]),
            .sample_en(opk[g]),
            .filter_en(filt_reg[g]),
            .arm(active[g]),
            .edge_pulse(edge_pulse[g])
         );
      end
   endgenerate

   // The counter acts on the registered tick, one pclk after the tick.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_q <= 8'h00;
         opk_q <= 8'h00;
      end else begin
         tick_q <= cnt_tick;
         opk_q <= opk;
      end
   end

   // ---------------------------------------------------------------
   // Channel counters (lower half when split)
   // ---------------------------------------------------------------
   // Stop wins over start when both land in one write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `TMR_NCH; i++) begin
            state_reg[i] <= CH_STOP;
            count_value_reg[i] <= 16'h0000;
         end
      end else begin
         for (int i = 0; i < `TMR_NCH; i++) begin
            if (stop_req[i]) begin
               state_reg[i] <= CH_STOP;
            end else if (start_req[i]) begin
               if (channel_mode_reg[i][`TMR_EVENT]) begin
                  count_value_reg[i] <= data_reg[i];
                  state_reg[i] <= CH_RUN;
               end else begin
                  state_reg[i] <= CH_WAIT;
               end
            end else begin
               case (state_reg[i])
                  CH_WAIT: begin
                     if (trig[i]) begin
                        count_value_reg[i] <= data_reg[i];
                        state_reg[i] <= CH_RUN;
                     end
                  end
                  CH_RUN: begin
                     if (tick_q[i]) begin
                        if (zero[i]) begin
                           count_value_reg[i] <= data_reg[i];
                        end else if (split[i]) begin
                           count_value_reg[i][7:0] <= count_value_reg[i][7:0] - 8'h01;
                        end else begin
                           count_value_reg[i] <= count_value_reg[i] - 16'h0001;
                        end
                     end
                  end
                  default: ;
               endcase
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 8'h00;
      end else begin
         for (int i = 0; i < `TMR_NCH; i++) begin
            irq_reg[i] <= !stop_req[i] && !start_req[i]
               && ((trig[i] && channel_mode_reg[i][`TMR_STIRQ])
               || (state_reg[i] == CH_RUN && tick_q[i] && zero[i]));
         end
      end
   end

   assign channel_irq = irq_reg;

   // ---------------------------------------------------------------
   // Upper halves of channels 1 and 3
   // ---------------------------------------------------------------
   // In sixteen-bit mode the upper state is frozen, not cleared.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int j = 0; j < 2; j++) begin
            up_state_reg[j] <= CH_STOP;
            up_cnt_reg[j] <= 8'h00;
         end
         up_irq_reg <= 2'b00;
      end else begin
         for (int j = 0; j < 2; j++) begin
            up_irq_reg[j] <= 1'b0;
            if (!split[2*j+1]) begin
               up_state_reg[j] <= up_state_reg[j];
            end else if (up_stop[j]) begin
               up_state_reg[j] <= CH_STOP;
            end else if (up_start[j]) begin
               up_state_reg[j] <= CH_WAIT;
            end else begin
               case (up_state_reg[j])
                  CH_WAIT: begin
                     if (opk_q[2*j+1]) begin
                        up_cnt_reg[j] <= data_reg[2*j+1][15:8];
                        up_irq_reg[j] <= 1'b1;
                        up_state_reg[j] <= CH_RUN;
                     end
                  end
                  CH_RUN: begin
                     if (opk_q[2*j+1]) begin
                        if (up_cnt_reg[j] == 8'h00) begin
                           up_cnt_reg[j] <= data_reg[2*j+1][15:8];
                           up_irq_reg[j] <= 1'b1;
                        end else begin
                           up_cnt_reg[j] <= up_cnt_reg[j] - 8'h01;
                        end
                     end
                  end
                  default: ;
               endcase
            end
         end
      end
   end

   assign upper_half_irq_ch1 = up_irq_reg[0];
   assign upper_half_irq_ch3 = up_irq_reg[1];

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   master_even_a: assert property (@(posedge pclk) disable iff (!presetn)
      (is_master & `TMR_ODD_MASK) == 8'h00)
      else $error("odd channel acting as master");

   chan0_master_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_master[0] && !channel_mode_reg[0][`TMR_MASTER] && !follow[0])
      else $error("channel zero not a plain master");

   for (g = 1; g < `TMR_NCH; g++) begin : g_own
      owner_map_a: assert property (@(posedge pclk) disable iff (!presetn)
         follow[g] |-> src_idx[g] < 3'(g) && is_master[src_idx[g]])
         else $error("slave routed to a non-master source");
   end

   presc_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      (prescaler_select_reg[3:0] != 4'h0 && opclk[0] && $stable(prescaler_select_reg))
      |=> !opclk[0] || $changed(prescaler_select_reg))
      else $error("divided operating clock wider than one cycle");

   presc_steady_a: assert property (@(posedge pclk) disable iff (!presetn)
      prescaler_select_reg[3:0] == 4'h0 |-> opclk[0])
      else $error("undivided operating clock not held high");

   count_late_a: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(state_reg[0]) == CH_RUN && state_reg[0] == CH_RUN
      && $changed(count_value_reg[0])) |-> $past(cnt_tick[0], 2))
      else $error("counter moved without a tick two edges back");

   start_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
      (trig[0] && channel_mode_reg[0][`TMR_STIRQ] && !start_req[0] && !stop_req[0])
      |=> irq_reg[0] ##1 !irq_reg[0] || $past(tick_q[0]))
      else $error("start interrupt missing or stretched");

   up_irq_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      (split[1] && up_state_reg[0] == CH_WAIT && opk_q[1] && !up_stop[0] && !up_start[0])
      |=> upper_half_irq_ch1 && up_state_reg[0] == CH_RUN)
      else $error("upper half did not interrupt at start");

   up_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
      !split[1] |=> $stable(up_state_reg[0]) && $stable(up_cnt_reg[0]))
      else $error("upper half changed in sixteen-bit mode");
endmodule // tmr_array
`default_nettype wire

// *** src/tmr_cfg.svh ***
// Address map, field positions and reset values of the timer array.
// Assumes inclusion by the package and the design modules only.
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
`define TMR_NCH 8
`define TMR_NOPCLK 4
`define TMR_PSEL_W 4
`define TMR_DIV_W 15
// Word segments of paddr[7:5] and control word index paddr[4:2].
`define TMR_SEG_MODE 3'h0
`define TMR_SEG_CTRL 3'h1
`define TMR_SEG_DATA 3'h2
`define TMR_SEG_COUNT 3'h4
`define TMR_CTRL_START 3'h0
`define TMR_CTRL_STOP 3'h1
`define TMR_CTRL_ACTIVE 3'h2
`define TMR_CTRL_PRESC 3'h3
`define TMR_CTRL_FILT 3'h4
// Channel mode register fields.
`define TMR_CKS_HI 15
`define TMR_CKS_LO 14
`define TMR_CSS 12
`define TMR_MASTER 11
`define TMR_SPLIT 11
`define TMR_SLAVE 10
`define TMR_EVENT 1
`define TMR_STIRQ 0
`define TMR_MODE_WMASK 16'hDC03
// Upper-half start, stop and active bits sit at this base plus channel.
`define TMR_UP_BASE 8
`define TMR_MODE_RST 16'h0000
`define TMR_DATA_RST 16'h0000
`define TMR_PRESC_RST 16'h0000
`define TMR_FILT_RST 8'h00
`define TMR_ODD_MASK 8'hAA
`endif

// *** src/tmr_pkg.sv ***
// Types shared by the timer array modules.
// Assumes the constants header is on the include path.
`default_nettype none
`include "tmr_cfg.svh"
package tmr_pkg;
   typedef enum {CH_STOP, CH_WAIT, CH_RUN} tmr_chan_state_t;
endpackage
`default_nettype wire

// *** src/tmr_edge_detect.sv ***
// Timer input pin synchroniser, optional noise filter and edge detector.
// Assumes sample_en is the channel operating clock tick on pclk.
`default_nettype none
`include "tmr_cfg.svh"
module tmr_edge_detect
   import tmr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin_in,
   input wire logic sample_en,
   input wire logic filter_en,
   input wire logic arm,
   output logic edge_pulse
);
   logic sync1_reg;
   logic sync2_reg;
   logic samp_reg;
   logic lvl_reg;
   logic lvl_next;
   logic edge_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   // The filter compares two successive operating-clock samples, so a
   // glitch shorter than one sample period never reaches the counter.
   always_comb begin
      lvl_next = lvl_reg;
      if (sample_en) begin
         if (!filter_en || sync2_reg == samp_reg) begin
            lvl_next = sync2_reg;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         samp_reg <= 1'b0;
         lvl_reg <= 1'b0;
         edge_reg <= 1'b0;
      end else begin
         if (sample_en) begin
            samp_reg <= sync2_reg;
         end
         lvl_reg <= lvl_next;
         edge_reg <= arm && lvl_next && !lvl_reg;
      end
   end

   assign edge_pulse = edge_reg;

   filt_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      ($changed(lvl_reg) && $past(filter_en)) |-> $past(samp_reg) == lvl_reg)
      else $error("filtered level accepted before two equal samples");

   edge_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
      edge_pulse |-> $past(arm) && lvl_reg && !$past(lvl_reg))
      else $error("edge pulse without armed rising sampled edge");
endmodule // tmr_edge_detect
`default_nettype wire

// *** sim/tmr_pin_model.sv ***
// Far-side model of the timer input pins, whose levels the bench commands.
// Assumes commands change just after a pclk edge.
`default_nettype none
module tmr_pin_model (
   input wire logic [7:0] level_cmd,
   output logic [7:0] pin
);
   timeunit 1ns;
   timeprecision 100ps;
   // The pins are asynchronous, so each change lands part way through a cycle.
   initial pin = 8'h00;
   always @(level_cmd) begin
      pin <= #7 level_cmd;
   end
endmodule // tmr_pin_model
`default_nettype wire

// *** sim/tmr_array_test.sv ***
// Self-checking bench for the timer array: APB access, ticks, split halves.
// Assumes the design package and header are compiled first.
`default_nettype none
module tmr_array_test import tmr_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] pin_cmd = 8'h00;
   logic [7:0] pin;
   logic [7:0] channel_irq;
   logic up1;
   logic up3;
   int fails = 0;
   int total_checks = 0;
   always #12.5 pclk = ~pclk;
   tmr_pin_model pins (.level_cmd(pin_cmd), .pin(pin));
   tmr_array uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_input_pin(pin), .channel_irq(channel_irq),
      .upper_half_irq_ch1(up1), .upper_half_irq_ch3(up3));
   task close_out;
      if (fails == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Holds the request until pready is seen high at a rising edge.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) fails++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge keeps the next request from re-raising psel in this step.
      @(posedge pclk);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task rd(input logic [11:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask
   // Index 8 selects the upper-half interrupt of channel one.
   task wait_hi(input int s, output int n);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (!((s == 8) ? up1 === 1'b1 : channel_irq[s] === 1'b1) && n < 40);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_regs;
      logic [31:0] r;
      logic e;
      rd(12'h028, r);
      chk("active_reset", r, 32'h0);
      apb(1'b0, 12'h034, 32'h0, r, e);
      chk("unmapped_err", {31'h0, e}, 32'h1);
      wr(12'h000, 32'h0000DC03);
      rd(12'h000, r);
      chk("mode0", r, 32'h0000D003);
      wr(12'h014, 32'h00000800);
      rd(12'h014, r);
      chk("mode5", r, 32'h0);
   endtask
   task t_split;
      logic [31:0] r;
      int n;
      wr(12'h004, 32'h0);
      wr(12'h020, 32'h00000200);
      rd(12'h028, r);
      chk("active_16bit", r, 32'h0);
      wr(12'h004, 32'h00000800);
      wr(12'h020, 32'h00000200);
      wait_hi(8, n);
      chk("upper_irq", {31'h0, n <= 8}, 32'h1);
      rd(12'h028, r);
      chk("active_split", r, 32'h00000200);
      wr(12'h024, 32'h00000200);
      rd(12'h028, r);
      chk("active_stop", r, 32'h0);
   endtask
   task t_interval;
      int n;
      wr(12'h02C, 32'h1);
      wr(12'h040, 32'h3);
      wr(12'h000, 32'h00000001);
      wr(12'h020, 32'h1);
      wait_hi(0, n);
      chk("start_irq", {31'h0, n <= 8}, 32'h1);
      wait_hi(0, n);
      chk("period", n, 32'h8);
      wr(12'h024, 32'h1);
   endtask
   task t_pin;
      logic [31:0] r;
      wr(12'h030, 32'h0);
      wr(12'h048, 32'h5);
      wr(12'h008, 32'h00001002);
      wr(12'h020, 32'h4);
      rd(12'h088, r);
      chk("pin_load", r, 32'h5);
      pin_cmd[2] <= 1'b1;
      repeat (10) @(posedge pclk);
      rd(12'h088, r);
      chk("pin_rise", r, 32'h4);
      pin_cmd[2] <= 1'b0;
      repeat (10) @(posedge pclk);
      rd(12'h088, r);
      chk("pin_fall", r, 32'h4);
      wr(12'h030, 32'h4);
      pin_cmd[2] <= 1'b1;
      repeat (12) @(posedge pclk);
      rd(12'h088, r);
      chk("pin_filter", r, 32'h3);
   endtask
   task t_group;
      logic [31:0] r;
      wr(12'h02C, 32'h0);
      wr(12'h050, 32'h1);
      wr(12'h054, 32'h9);
      wr(12'h010, 32'h00000801);
      wr(12'h014, 32'h00000402);
      wr(12'h020, 32'h30);
      repeat (10) @(posedge pclk);
      wr(12'h024, 32'h30);
      rd(12'h094, r);
      chk("slave_follows", r, 32'h4);
      rd(12'h028, r);
      chk("group_stop", r & 32'h30, 32'h0);
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_split();
      t_interval();
      t_pin();
      t_group();
      close_out();
   end
   initial begin
      #100000;
      fails++;
      close_out();
   end
endmodule // tmr_array_test
`default_nettype wire
